// file: rtl/pgc_defs.svh
// Register offsets, field layouts, reset values and timing constants of the group config bank
// Overview of operation
// RULE1 - The group word holds a 5-bit rail id (0 to 31) in bits 12:8 used to address sharing, sequencing and fault spreading.
// RULE2 - The host gives every regulator of one sharing group the same rail id.
// RULE3 - Bits 15:13 hold the position in the sharing group minus one, codes 00 to 11 for positions 1 to 4.
// RULE4 - Bits 3:0 give the phase count with odd codes 1, 3, 5, 7 meaning 2, 4, 6, 8 phases.
// RULE5 - Power-ok is raised only after the output has stayed above its on threshold for the programmed delay in ms, at most 5000 ms.
// RULE6 - The programmed delay is rounded to the nearest whole millisecond before use.
// RULE7 - An 8-bit gain in bits 7:0 sets the shared ramp rise time, smaller gain meaning a longer ramp.
// RULE8 - When sharing current the shared ramp mode is chosen by itself and the high-bandwidth turn-on ramp is off.
// RULE9 - Once power-ok is raised during a shared start-up the normal high-bandwidth loop returns.
// RULE10 - When sharing current no soft-off ramp is done and the turn-off fall time is ignored.
// RULE11 - A 16-bit inductor value in uH, range 0 to 100, feeds the ripple current calculations.
// RULE12 - A 1 in a snapshot mask bit stops that fault from causing a snapshot write, a 0 lets it.
// RULE13 - Mask bits 13 to 8 are group rail, phase, processor, memory CRC, monitor UV and monitor OV faults.
// RULE14 - Mask bits 7 to 0 are out UC, out OC, in UV, in OV, under temp, over temp, out UV and out OV faults.
// RULE15 - Unassigned bits read as zero and ignore writes.
`ifndef PGC_DEFS_SVH
`define PGC_DEFS_SVH

`define PGC_OFS_GROUP_CFG   8'hD3
`define PGC_OFS_PG_DELAY    8'hD4
`define PGC_OFS_RAMP_GAIN   8'hD5
`define PGC_OFS_INDUCTOR    8'hD6
`define PGC_OFS_SNAP_MASK   8'hD7

`define PGC_GROUP_CFG_MASK  16'hFF0F
`define PGC_PG_DELAY_MASK   16'hFFFF
`define PGC_RAMP_GAIN_MASK  16'h00FF
`define PGC_INDUCTOR_MASK   16'hFFFF
`define PGC_SNAP_MASK_MASK  16'h3FFF

`define PGC_RAIL_ID_LSB     8
`define PGC_RAIL_ID_MSB     12
`define PGC_POS_LSB         13
`define PGC_POS_MSB         15
`define PGC_PHASES_LSB      0
`define PGC_PHASES_MSB      3

`define PGC_GROUP_CFG_RST   16'h0000
`define PGC_PG_DELAY_RST    16'h0000
`define PGC_RAMP_GAIN_RST   16'h0000
`define PGC_INDUCTOR_RST    16'h0000
`define PGC_SNAP_MASK_RST   16'h0000

`define PGC_PG_DELAY_MAX_MS 16'h1388
`define PGC_INDUCTOR_MAX_UH 16'h0064
`define PGC_MS_NS           1000000
`define PGC_CLK_NS          5
`define PGC_CYC_PER_MS      (`PGC_MS_NS / `PGC_CLK_NS)

`endif

// file: rtl/pgc_pkg.sv
// Types shared by the group config bank
`default_nettype none
package pgc_pkg;
    // One bit per fault source, bit order as in the snapshot mask
    typedef struct packed {
        logic group_rail;
        logic phase;
        logic processor;
        logic mem_crc;
        logic mon_uv;
        logic mon_ov;
        logic out_uc;
        logic out_oc;
        logic in_uv;
        logic in_ov;
        logic under_temp;
        logic over_temp;
        logic out_uv;
        logic out_ov;
    } pgc_fault_t;

    // Decoded command from the management port
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } pgc_cmd_t;

    // Answer to a command
    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] rdata;
    } pgc_rsp_t;

    typedef enum logic [1:0] {
        PGC_OFF,
        PGC_RAMP,
        PGC_RUN
    } pgc_phase_t;

    typedef struct packed {
        logic [17:0] cyc;
        logic [12:0] ms;
        logic        ok;
    } pgc_timer_t;
endpackage
`default_nettype wire

// file: rtl/pgc_pg_timer.sv
// Power-ok delay timer counting whole milliseconds above threshold
`timescale 1ns/1ps
`default_nettype none
`include "pgc_defs.svh"
module pgc_pg_timer #(
    parameter int unsigned CYC_PER_MS = `PGC_CYC_PER_MS
) (
    input  wire logic        clk_i,       // Control clock
    input  wire logic        rst_i,       // Async reset, high
    input  wire logic        above_i,     // Output above on threshold
    input  wire logic [12:0] delay_ms_i,  // Rounded delay in ms
    output logic             ok_o         // Power-ok, registered
);
    import pgc_pkg::*;

    pgc_timer_t s_q;
    pgc_timer_t s_d;

    localparam logic [17:0] CYC_LAST = 18'(CYC_PER_MS - 1);

    // Any dip below threshold restarts the wait from zero
    always_comb begin
        s_d = s_q;
        if (!above_i) begin
            s_d = '0;
        end else if (s_q.ms >= delay_ms_i) begin
            s_d.ok = 1'b1;  // see RULE5
        end else if (s_q.cyc == CYC_LAST) begin
            s_d.cyc = '0;
            s_d.ms  = s_q.ms + 13'h1;
        end else begin
            s_d.cyc = s_q.cyc + 18'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ok_o = s_q.ok;
endmodule
`default_nettype wire

// file: rtl/pgc_top.sv
// Group bus, power-ok delay, ramp gain, inductor and snapshot mask register bank
`timescale 1ns/1ps
`default_nettype none
`include "pgc_defs.svh"
module pgc_top #(
    parameter int unsigned CYC_PER_MS = `PGC_CYC_PER_MS
) (
    input  wire logic                clk_i,            // Control clock, 200 MHz
    input  wire logic                rst_i,            // Async reset, high
    input  wire pgc_pkg::pgc_cmd_t   cmd_i,            // Decoded management command
    output pgc_pkg::pgc_rsp_t        rsp_o,            // Command answer, one cycle later
    input  wire logic                enable_i,         // Output turn-on request
    input  wire logic                above_pg_on_i,    // Output above power-ok on level
    input  wire pgc_pkg::pgc_fault_t fault_i,          // One-cycle fault events
    output logic                     power_ok_pin_o,   // Power-ok pin level
    output logic [4:0]               rail_id_o,        // Group comm bus rail id
    output logic [2:0]               group_pos_o,      // Position in group minus one
    output logic [3:0]               phase_count_o,    // Phases on the rail
    output logic                     sharing_o,        // Current sharing configured
    output logic                     shared_ramp_o,    // Shared ramp mode active
    output logic                     hb_loop_en_o,     // High-bandwidth loop enabled
    output logic                     soft_off_en_o,    // Soft-off ramps permitted
    output logic [7:0]               ramp_gain_o,      // Shared ramp gain
    output logic [6:0]               inductor_uh_o,    // Rounded inductor in uH
    output logic                     snapshot_req_o,   // Snapshot write request pulse
    output pgc_pkg::pgc_fault_t      snapshot_src_o    // Faults that caused it
);
    import pgc_pkg::*;

    // Whole bank state, derived controls included, so every output leaves a flop
    typedef struct packed {
        logic [15:0] group_cfg;
        logic [15:0] pg_delay;
        logic [15:0] ramp_gain;
        logic [15:0] inductor;
        logic [15:0] snap_mask;
        logic [12:0] delay_ms;
        logic [6:0]  ind_uh;
        pgc_phase_t  phase;
        pgc_rsp_t    rsp;
        logic        snap_req;
        pgc_fault_t  snap_src;
        logic [3:0]  phase_cnt;
        logic        sharing;
        logic        shr_ramp;
        logic        hb_en;
        logic        soft_en;
        logic        pg;
    } pgc_bank_t;

    pgc_bank_t s_q;
    pgc_bank_t s_d;
    logic      pg_ok;

    // Linear word to a rounded, clamped integer; negative values become zero
    function automatic logic [15:0] lin_round(input logic [15:0] v, input logic [15:0] lim);
        logic signed [4:0] ex;
        logic [4:0]        sh;
        logic [31:0]       m;
        logic [31:0]       r;
        ex = v[15:11];
        m  = {21'h0, v[10:0]};
        r  = 32'h0;
        // Mantissa sign set means a negative value, which has no meaning here
        if (v[10]) begin
            r = 32'h0;
        end else if (ex >= 0) begin
            r = m << ex;
        end else begin
            sh = 5'(-ex);
            r  = (m + (32'h1 << (sh - 5'h1))) >> sh;
        end
        if (r > {16'h0, lim}) begin
            r = {16'h0, lim};
        end
        return r[15:0];
    endfunction

    // Read-back mux; unmapped codes give an error
    function automatic logic [16:0] rd_word(input pgc_bank_t s, input logic [7:0] code);
        if (code == `PGC_OFS_GROUP_CFG) begin
            rd_word = {1'b0, s.group_cfg};
        end else if (code == `PGC_OFS_PG_DELAY) begin
            rd_word = {1'b0, s.pg_delay};
        end else if (code == `PGC_OFS_RAMP_GAIN) begin
            rd_word = {1'b0, s.ramp_gain};
        end else if (code == `PGC_OFS_INDUCTOR) begin
            rd_word = {1'b0, s.inductor};
        end else if (code == `PGC_OFS_SNAP_MASK) begin
            rd_word = {1'b0, s.snap_mask};
        end else begin
            rd_word = 17'h10000;
        end
    endfunction

    // Helpers for the write path, the read mux, the snapshot logic and the derived controls
    logic [15:0] dly_rounded;
    logic [15:0] ind_rounded;
    logic        sharing;
    logic [16:0] rd;
    logic [13:0] snap_hits;

    // Rounding is done on the incoming word so the timer never sees a linear value
    always_comb begin
        dly_rounded = lin_round(cmd_i.wdata, `PGC_PG_DELAY_MAX_MS);
        ind_rounded = lin_round(cmd_i.wdata, `PGC_INDUCTOR_MAX_UH);
        sharing     = (s_q.group_cfg[`PGC_PHASES_MSB:`PGC_PHASES_LSB] != 4'h0);
        rd          = rd_word(s_q, cmd_i.code);
        snap_hits   = fault_i & ~s_q.snap_mask[13:0];  // see RULE12 see RULE13 see RULE14
    end

    // Register writes and answers; unassigned bits are masked off
    always_comb begin
        s_d           = s_q;
        s_d.rsp       = '0;
        s_d.snap_req  = 1'b0;
        s_d.snap_src  = '0;
        if (cmd_i.valid) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.err   = rd[16];
            s_d.rsp.rdata = cmd_i.write ? 16'h0000 : rd[15:0];
            if (cmd_i.write) begin
                // Position codes above 3 are kept as written; only 0 to 3 name real slots
                if (cmd_i.code == `PGC_OFS_GROUP_CFG) begin
                    s_d.group_cfg = cmd_i.wdata & `PGC_GROUP_CFG_MASK;  // see RULE1 see RULE3 see RULE4 see RULE15
                end else if (cmd_i.code == `PGC_OFS_PG_DELAY) begin
                    s_d.pg_delay = cmd_i.wdata & `PGC_PG_DELAY_MASK;
                    s_d.delay_ms = dly_rounded[12:0];  // see RULE6
                end else if (cmd_i.code == `PGC_OFS_RAMP_GAIN) begin
                    s_d.ramp_gain = cmd_i.wdata & `PGC_RAMP_GAIN_MASK;  // see RULE7 see RULE15
                end else if (cmd_i.code == `PGC_OFS_INDUCTOR) begin
                    s_d.inductor = cmd_i.wdata & `PGC_INDUCTOR_MASK;
                    s_d.ind_uh   = ind_rounded[6:0];  // see RULE11
                end else if (cmd_i.code == `PGC_OFS_SNAP_MASK) begin
                    s_d.snap_mask = cmd_i.wdata & `PGC_SNAP_MASK_MASK;  // see RULE15
                end
            end
        end
        // Snapshot request only for faults whose mask bit is clear
        if (snap_hits != 14'h0) begin
            s_d.snap_req = 1'b1;
            s_d.snap_src = snap_hits;
        end
        // Start-up sequence steers the loop bandwidth
        case (s_q.phase)
            PGC_OFF: begin
                if (enable_i) begin
                    s_d.phase = PGC_RAMP;
                end
            end
            // Leaving the ramp waits for the internal ok, so the pin and the loop switch together
            PGC_RAMP: begin
                if (!enable_i) begin
                    s_d.phase = PGC_OFF;
                end else if (pg_ok) begin
                    s_d.phase = PGC_RUN;  // see RULE9
                end
            end
            PGC_RUN: begin
                if (!enable_i) begin
                    s_d.phase = PGC_OFF;
                end
            end
            default: begin
                s_d.phase = PGC_OFF;
            end
        endcase
        // Derived controls are state too, so each output leaves a flop with no logic behind it
        s_d.phase_cnt = s_d.group_cfg[`PGC_PHASES_MSB:`PGC_PHASES_LSB] + 4'h1;  // see RULE4
        s_d.sharing   = sharing;
        s_d.shr_ramp  = sharing && (s_d.phase == PGC_RAMP);     // see RULE8
        s_d.hb_en     = !(sharing && (s_d.phase == PGC_RAMP));  // see RULE8 see RULE9
        s_d.soft_en   = !sharing;                               // see RULE10
        s_d.pg        = pg_ok;                                  // see RULE5
    end

    // One register for the whole bank state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q           <= '0;
            s_q.group_cfg <= `PGC_GROUP_CFG_RST;
            s_q.pg_delay  <= `PGC_PG_DELAY_RST;
            s_q.ramp_gain <= `PGC_RAMP_GAIN_RST;
            s_q.inductor  <= `PGC_INDUCTOR_RST;
            s_q.snap_mask <= `PGC_SNAP_MASK_RST;
            s_q.phase     <= PGC_OFF;
            s_q.phase_cnt <= 4'h1;
            // Loop bandwidth and soft-off start enabled, as for a lone regulator
            s_q.hb_en     <= 1'b1;
            s_q.soft_en   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Delay counter works on the rounded copy, not the raw linear word
    pgc_pg_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .above_i    (above_pg_on_i && enable_i),
        .delay_ms_i (s_q.delay_ms),
        .ok_o       (pg_ok)
    );

    // Every output is a plain view of a state flop
    assign rsp_o          = s_q.rsp;
    assign power_ok_pin_o = s_q.pg;
    assign rail_id_o      = s_q.group_cfg[`PGC_RAIL_ID_MSB:`PGC_RAIL_ID_LSB];
    assign group_pos_o    = s_q.group_cfg[`PGC_POS_MSB:`PGC_POS_LSB];
    assign phase_count_o  = s_q.phase_cnt;
    assign sharing_o      = s_q.sharing;
    assign shared_ramp_o  = s_q.shr_ramp;
    assign hb_loop_en_o   = s_q.hb_en;
    assign soft_off_en_o  = s_q.soft_en;
    assign ramp_gain_o    = s_q.ramp_gain[7:0];
    assign inductor_uh_o  = s_q.ind_uh;
    assign snapshot_req_o = s_q.snap_req;
    assign snapshot_src_o = s_q.snap_src;
endmodule
`default_nettype wire

// file: sim/pgc_top_assertions.sv
// Concurrent checks on the group config bank ports
`timescale 1ns/1ps
`default_nettype none
module pgc_checker (
    input wire logic                clk_i,          // Control clock
    input wire logic                rst_i,          // Async reset, high
    input wire pgc_pkg::pgc_cmd_t   cmd_i,          // Command in
    input wire pgc_pkg::pgc_rsp_t   rsp_o,          // Command answer
    input wire logic                above_pg_on_i,  // Above power-ok level
    input wire pgc_pkg::pgc_fault_t fault_i,        // Fault events
    input wire logic                power_ok_pin_o, // Power-ok pin
    input wire logic [4:0]          rail_id_o,      // Rail id
    input wire logic                sharing_o,      // Sharing configured
    input wire logic                shared_ramp_o,  // Shared ramp active
    input wire logic                hb_loop_en_o,   // High-bandwidth loop
    input wire logic                soft_off_en_o,  // Soft-off allowed
    input wire logic [7:0]          ramp_gain_o,    // Ramp gain
    input wire logic                snapshot_req_o, // Snapshot request
    input wire pgc_pkg::pgc_fault_t snapshot_src_o  // Snapshot sources
);
    import pgc_pkg::*;
    // One clock domain, so one default clock and reset for all checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_rsp_one_cycle: assert property (rsp_o.valid == $past(cmd_i.valid))
        else $error("answer not one cycle after command");
    a_rail_by_write: assert property ($changed(rail_id_o) |-> $past(cmd_i.valid && cmd_i.write && cmd_i.code == 8'hD3))
        else $error("rail id moved without a write");
    a_gain_by_write: assert property ($changed(ramp_gain_o) |-> $past(cmd_i.valid && cmd_i.write && cmd_i.code == 8'hD5))
        else $error("ramp gain moved without a write");
    a_hb_loop_off: assert property (hb_loop_en_o != shared_ramp_o)
        else $error("high-bandwidth loop and shared ramp overlap");
    a_ramp_needs_share: assert property (shared_ramp_o |-> sharing_o)
        else $error("shared ramp without sharing");
    a_soft_off_gate: assert property (soft_off_en_o == !sharing_o)
        else $error("soft-off allowed while sharing");
    a_ramp_ends_ok: assert property (power_ok_pin_o |-> !shared_ramp_o)
        else $error("shared ramp still on after power ok");
    a_snap_idle: assert property (!snapshot_req_o |-> snapshot_src_o == '0)
        else $error("snapshot sources without request");
    a_snap_cause: assert property (snapshot_req_o |-> snapshot_src_o != '0 && (snapshot_src_o & ~$past(fault_i)) == '0)
        else $error("snapshot source without fault");
    a_pg_drop: assert property ($fell(above_pg_on_i) |-> ##[1:3] !power_ok_pin_o)
        else $error("power ok held after output fell");
endmodule
bind pgc_top pgc_checker u_chk (.clk_i, .rst_i, .cmd_i, .rsp_o, .above_pg_on_i, .fault_i, .power_ok_pin_o,
    .rail_id_o, .sharing_o, .shared_ramp_o, .hb_loop_en_o, .soft_off_en_o, .ramp_gain_o, .snapshot_req_o,
    .snapshot_src_o);
`default_nettype wire

// file: sim/pgc_host_model.sv
// Management host model issuing one-cycle commands
`timescale 1ns/1ps
`default_nettype none
module pgc_host_model (
    input wire logic              clk_i, // Control clock
    input wire pgc_pkg::pgc_rsp_t rsp_i, // Answer from the bank
    output pgc_pkg::pgc_cmd_t     cmd_o  // Command to the bank
);
    import pgc_pkg::*;
    initial cmd_o = '0;
    // One command, answer taken in the following cycle; the caller keeps rail ids equal per group
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, output pgc_rsp_t rsp);
        @(negedge clk_i);
        cmd_o = {1'b1, wr, code, wd};
        @(negedge clk_i);
        rsp = rsp_i;
        // Released fields flip so stale values are never mistaken for data
        cmd_o = {1'b0, ~wr, ~code, ~wd};
    endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the group config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pgc_pkg::*;
    localparam int unsigned CPM = 4; // Short millisecond keeps runs brief
    logic clk_i = 0, rst_i = 1, enable_i = 0, above_pg_on_i = 0;
    logic power_ok_pin_o, sharing_o, shared_ramp_o, hb_loop_en_o, soft_off_en_o, snapshot_req_o;
    logic [4:0] rail_id_o;
    logic [2:0] group_pos_o;
    logic [3:0] phase_count_o;
    logic [7:0] ramp_gain_o;
    logic [6:0] inductor_uh_o;
    pgc_cmd_t   cmd_i;
    pgc_rsp_t   rsp_o;
    pgc_fault_t fault_i = '0, snapshot_src_o;
    int num_errors = 0, checked = 0;
    always #2.5 clk_i = ~clk_i;
    pgc_host_model host (.clk_i(clk_i), .rsp_i(rsp_o), .cmd_o(cmd_i));
    pgc_top #(.CYC_PER_MS(CPM)) dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
        .enable_i(enable_i), .above_pg_on_i(above_pg_on_i), .fault_i(fault_i), .power_ok_pin_o(power_ok_pin_o),
        .rail_id_o(rail_id_o), .group_pos_o(group_pos_o), .phase_count_o(phase_count_o), .sharing_o(sharing_o),
        .shared_ramp_o(shared_ramp_o), .hb_loop_en_o(hb_loop_en_o), .soft_off_en_o(soft_off_en_o),
        .ramp_gain_o(ramp_gain_o), .inductor_uh_o(inductor_uh_o), .snapshot_req_o(snapshot_req_o),
        .snapshot_src_o(snapshot_src_o));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        pgc_rsp_t r;
        host.xfer(1'b1, c, d, r);
        chk({r.valid, r.err}, 16'h0002);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        pgc_rsp_t r;
        host.xfer(1'b0, c, 16'h0000, r);
        chk(r.rdata, e);
    endtask
    // Bounded wait for power ok, returns cycles taken
    task automatic wait_pg(output int n);
        n = 0;
        while (power_ok_pin_o !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic t_regs;
        pgc_rsp_t r;
        for (int i = 0; i < 5; i++) rd(8'(8'hD3 + i), 16'h0000);
        wr(8'hD3, 16'hFFFF);
        rd(8'hD3, 16'hFF0F);
        wr(8'hD5, 16'hFFFF);
        rd(8'hD5, 16'h00FF);
        chk(ramp_gain_o, 16'h00FF);
        wr(8'hD7, 16'hFFFF);
        rd(8'hD7, 16'h3FFF);
        wr(8'hD6, 16'h0064);
        rd(8'hD6, 16'h0064);
        chk(inductor_uh_o, 16'h0064);
        wr(8'hD6, 16'h0819); // Exponent 1: 25 * 2 uH
        chk(inductor_uh_o, 16'h0032);
        wr(8'hD6, 16'h00C8); // 200 uH, clamped to the top of the range
        chk(inductor_uh_o, 16'h0064);
        wr(8'hD6, 16'hF805); // 2.5 uH, the half rounds up
        chk(inductor_uh_o, 16'h0003);
        wr(8'hD6, 16'h07FF); // Negative mantissa gives zero
        chk(inductor_uh_o, 16'h0000);
        wr(8'hD3, 16'hA705);
        chk(rail_id_o, 16'h0007);
        chk(group_pos_o, 16'h0005);
        for (int k = 0; k < 4; k++) begin
            wr(8'hD3, 16'(2 * k + 1));
            @(negedge clk_i);
            chk(phase_count_o, 16'(2 * k + 2));
            chk(sharing_o, 16'h0001);
        end
        host.xfer(1'b0, 8'hD8, 16'h0000, r);
        chk({r.valid, r.err}, 16'h0003);
        wr(8'hD3, 16'h0000);
    endtask
    task automatic t_pg;
        int n;
        wr(8'hD4, 16'hF803); // Half-step value of 1.5 ms
        enable_i = 1;
        above_pg_on_i = 1;
        wait_pg(n);
        // Counted from the first sampled high: ms steps, then internal ok, then the pin flop
        chk(16'(n), 16'(2 * CPM + 2));
        above_pg_on_i = 0;
        repeat (3) @(negedge clk_i);
        chk(power_ok_pin_o, 16'h0000);
        enable_i = 0;
    endtask
    task automatic t_share;
        int n;
        wr(8'hD3, 16'h0103);
        @(negedge clk_i);
        chk(soft_off_en_o, 16'h0000);
        enable_i = 1;
        above_pg_on_i = 1;
        @(negedge clk_i);
        chk({shared_ramp_o, hb_loop_en_o}, 16'h0002);
        wait_pg(n);
        chk({shared_ramp_o, hb_loop_en_o}, 16'h0001);
        enable_i = 0;
        above_pg_on_i = 0;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic t_snap;
        for (int i = -1; i < 14; i++) begin
            wr(8'hD7, (i < 0) ? 16'h3FFF : 16'h3FFF ^ (16'h0001 << i));
            fault_i = '1;
            @(negedge clk_i);
            fault_i = '0;
            chk(snapshot_req_o, (i < 0) ? 16'h0000 : 16'h0001);
            chk(snapshot_src_o, (i < 0) ? 16'h0000 : 16'h0001 << i);
        end
    endtask
    // Reset in mid-run must bring the loop, soft-off, sharing, phase count and ramp gain controls back to their idle levels
    task automatic t_reset;
        @(negedge clk_i);
        rst_i = 1;
        @(negedge clk_i);
        chk({hb_loop_en_o, soft_off_en_o, sharing_o}, 16'h0006);
        chk(phase_count_o, 16'h0001);
        chk(ramp_gain_o, 16'h0000);
        rst_i = 0;
        rd(8'hD3, 16'h0000);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        t_regs;
        t_pg;
        t_share;
        t_snap;
        t_reset;
        print_verdict;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #50000;
        num_errors++;
        print_verdict;
    end
endmodule
`default_nettype wire
